// [rtl/smi_defines.svh]
// Constants for the shift, move and indirect-load execution block.
// Assumes inclusion by bare name from the package and the core.
`ifndef SMI_DEFINES_SVH
`define SMI_DEFINES_SVH

// Register port offsets
`define SMI_REG_WORK      3'h0
`define SMI_REG_STATUS    3'h1
`define SMI_REG_PTR0_LO   3'h2
`define SMI_REG_PTR0_HI   3'h3
`define SMI_REG_PTR1_LO   3'h4
`define SMI_REG_PTR1_HI   3'h5

// Status field positions
`define SMI_STAT_CARRY    0
`define SMI_STAT_ZERO     1

// Reset values
`define SMI_WORK_RST      8'h00
`define SMI_PTR_RST       16'h0000
`define SMI_DATA_ZERO     8'h00

// Pointer step and widths
`define SMI_PTR_STEP      16'h0001
`define SMI_PTR_W         16
`define SMI_FADDR_W       7
`define SMI_OFFSET_W      6

// Clocks from issue to completion pulse
`define SMI_EXEC_CYCLES   3

`endif

// [rtl/smi_pkg.sv]
// Types for the shift, move and indirect-load execution block.
// Assumes smi_defines.svh is on the include path.
`include "smi_defines.svh"

package smi_pkg;

   typedef enum logic [1:0] {
      op_shift_right = 2'b00,
      op_move_file   = 2'b01,
      op_iload       = 2'b10
   } smi_op_e;

   typedef enum logic [1:0] {
      mode_pre_inc  = 2'b00,
      mode_pre_dec  = 2'b01,
      mode_post_inc = 2'b10,
      mode_post_dec = 2'b11
   } smi_mode_e;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_read = 2'b01,
      st_exec = 2'b10
   } smi_state_e;

   typedef struct packed {
      smi_op_e                   op;
      logic [`SMI_FADDR_W-1:0]   faddr;
      logic                      dest;
      logic                      ptr_sel;
      logic                      relative;
      smi_mode_e                 pointer_update_mode;
      logic [`SMI_OFFSET_W-1:0]  offset;
   } smi_instr_s;

endpackage

// [rtl/smi_core.sv]
// Execution of right shift, file move and indirect load into the working register.
// Assumes a core sequencer issuing one instruction at a time and a one-cycle memory read path.
`timescale 1ns/100ps
`include "smi_defines.svh"

module smi_core (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  srst,
   // Instruction issue
   input  smi_pkg::smi_instr_s        instr,
   input  wire logic                  instr_valid,
   output logic                       instr_ready,
   output logic                       instr_done,
   // Operand read path
   output logic                       mem_rd_en,
   output logic [`SMI_PTR_W-1:0]      mem_rd_addr,
   output logic                       mem_rd_indirect,
   input  wire logic [7:0]            mem_rd_data,
   // File register write-back
   output logic                       file_wr_en,
   output logic [`SMI_FADDR_W-1:0]    file_wr_addr,
   output logic [7:0]                 file_wr_data,
   // Register port
   input  wire logic [2:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [7:0]                 reg_rdata,
   // Core state
   output logic [7:0]                 work_reg,
   output logic                       carry_flag,
   output logic                       zero_flag
);

   smi_pkg::smi_state_e        state_r;
   smi_pkg::smi_instr_s        instr_r;
   logic [`SMI_PTR_W-1:0]      ptr_r [2];
   logic [`SMI_PTR_W-1:0]      sel_ptr;
   logic                       take;
   logic                       in_exec;
   logic [7:0]                 res_nxt;
   logic                       carry_nxt;
   logic                       to_work;

   // Pointer stepped by one, wrapping
   function automatic logic [`SMI_PTR_W-1:0] ptr_step(input logic [`SMI_PTR_W-1:0] p,
                                                       input smi_pkg::smi_mode_e m);
      ptr_step = m[0] ? p - `SMI_PTR_STEP : p + `SMI_PTR_STEP;
   endfunction

   // Effective address of an indirect load
   function automatic logic [`SMI_PTR_W-1:0] eff_addr(input logic [`SMI_PTR_W-1:0] p,
                                                       input smi_pkg::smi_instr_s i);
      if (i.relative) begin
         eff_addr = p + {{(`SMI_PTR_W-`SMI_OFFSET_W){i.offset[`SMI_OFFSET_W-1]}}, i.offset};
      end else if (!i.pointer_update_mode[1]) begin
         eff_addr = ptr_step(p, i.pointer_update_mode);
      end else begin
         eff_addr = p;
      end
   endfunction

   assign sel_ptr = ptr_r[instr.ptr_sel];
   assign take    = instr_valid && (state_r == smi_pkg::st_idle);
   assign in_exec = (state_r == smi_pkg::st_exec);
   assign to_work = (instr_r.op == smi_pkg::op_iload) || !instr_r.dest;

   // Sequencer: issue, read, execute
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_r <= smi_pkg::st_idle;
      end else begin
         unique case (state_r)
            smi_pkg::st_idle: if (take) state_r <= smi_pkg::st_read;
            smi_pkg::st_read: state_r <= smi_pkg::st_exec;
            smi_pkg::st_exec: state_r <= smi_pkg::st_idle;
            default:          state_r <= smi_pkg::st_idle;
         endcase
      end
   end

   // Handshake outputs
   always_ff @(posedge mclk) begin
      if (srst) begin
         instr_ready <= 1'b1;
         instr_done  <= 1'b0;
      end else begin
         instr_ready <= in_exec || (instr_ready && !take);
         instr_done  <= in_exec;
      end
   end

   // Latched instruction
   always_ff @(posedge mclk) begin
      if (srst) begin
         instr_r <= '0;
      end else if (take) begin
         instr_r <= instr;
      end
   end

   // Operand read request
   always_ff @(posedge mclk) begin
      if (srst) begin
         mem_rd_en       <= 1'b0;
         mem_rd_addr     <= `SMI_PTR_RST;
         mem_rd_indirect <= 1'b0;
      end else begin
         mem_rd_en <= take;
         if (take) begin
            mem_rd_indirect <= (instr.op == smi_pkg::op_iload);
            if (instr.op == smi_pkg::op_iload) begin
               mem_rd_addr <= eff_addr(sel_ptr, instr);
            end else begin
               mem_rd_addr <= {{(`SMI_PTR_W-`SMI_FADDR_W){1'b0}}, instr.faddr};
            end
         end
      end
   end

   // Result of the instruction in execute
   always_comb begin
      res_nxt   = mem_rd_data;
      carry_nxt = carry_flag;
      if (instr_r.op == smi_pkg::op_shift_right) begin
         res_nxt   = {1'b0, mem_rd_data[7:1]};
         carry_nxt = mem_rd_data[0];
      end
   end

   // Working register
   always_ff @(posedge mclk) begin
      if (srst) begin
         work_reg <= `SMI_WORK_RST;
      end else if (in_exec && to_work) begin
         work_reg <= res_nxt;
      end else if (reg_wr && reg_addr == `SMI_REG_WORK) begin
         work_reg <= reg_wdata;
      end
   end

   // Status flags
   always_ff @(posedge mclk) begin
      if (srst) begin
         carry_flag <= 1'b0;
         zero_flag  <= 1'b0;
      end else if (in_exec) begin
         carry_flag <= carry_nxt;
         zero_flag  <= (res_nxt == `SMI_DATA_ZERO);
      end else if (reg_wr && reg_addr == `SMI_REG_STATUS) begin
         carry_flag <= reg_wdata[`SMI_STAT_CARRY];
         zero_flag  <= reg_wdata[`SMI_STAT_ZERO];
      end
   end

   // File register write-back
   always_ff @(posedge mclk) begin
      if (srst) begin
         file_wr_en   <= 1'b0;
         file_wr_addr <= '0;
         file_wr_data <= `SMI_DATA_ZERO;
      end else begin
         file_wr_en <= in_exec && !to_work;
         if (in_exec) begin
            file_wr_addr <= instr_r.faddr;
            file_wr_data <= res_nxt;
         end
      end
   end

   // Pointer registers
   for (genvar g = 0; g < 2; g++) begin : g_ptr
      logic hit_lo;
      logic hit_hi;
      logic pre_upd;
      logic post_upd;
      assign hit_lo   = reg_wr && (reg_addr == 3'(`SMI_REG_PTR0_LO + 2 * g));
      assign hit_hi   = reg_wr && (reg_addr == 3'(`SMI_REG_PTR0_HI + 2 * g));
      assign pre_upd  = take && instr.op == smi_pkg::op_iload && !instr.relative
                        && !instr.pointer_update_mode[1] && instr.ptr_sel == 1'(g);
      assign post_upd = in_exec && instr_r.op == smi_pkg::op_iload && !instr_r.relative
                        && instr_r.pointer_update_mode[1] && instr_r.ptr_sel == 1'(g);
      always_ff @(posedge mclk) begin
         if (srst) begin
            ptr_r[g] <= `SMI_PTR_RST;
         end else if (pre_upd) begin
            ptr_r[g] <= ptr_step(ptr_r[g], instr.pointer_update_mode);
         end else if (post_upd) begin
            ptr_r[g] <= ptr_step(ptr_r[g], instr_r.pointer_update_mode);
         end else if (hit_lo) begin
            ptr_r[g] <= {ptr_r[g][15:8], reg_wdata};
         end else if (hit_hi) begin
            ptr_r[g] <= {reg_wdata, ptr_r[g][7:0]};
         end
      end
   end

   // Register port read data
   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_rdata <= `SMI_DATA_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `SMI_REG_WORK:    reg_rdata <= work_reg;
            `SMI_REG_STATUS:  reg_rdata <= {6'h00, zero_flag, carry_flag};
            `SMI_REG_PTR0_LO: reg_rdata <= ptr_r[0][7:0];
            `SMI_REG_PTR0_HI: reg_rdata <= ptr_r[0][15:8];
            `SMI_REG_PTR1_LO: reg_rdata <= ptr_r[1][7:0];
            `SMI_REG_PTR1_HI: reg_rdata <= ptr_r[1][15:8];
            default:          reg_rdata <= `SMI_DATA_ZERO;
         endcase
      end else begin
         reg_rdata <= `SMI_DATA_ZERO;
      end
   end

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   logic is_shift;
   logic is_move;
   logic is_iload;
   assign is_shift = in_exec && instr_r.op == smi_pkg::op_shift_right;
   assign is_move  = in_exec && instr_r.op == smi_pkg::op_move_file;
   assign is_iload = in_exec && instr_r.op == smi_pkg::op_iload;

   property p_shift_carry;
      is_shift |=> carry_flag == $past(mem_rd_data[0]);
   endproperty
   a_shift_carry: assert property (p_shift_carry) else $error("shift carry wrong");

   property p_shift_file;
      is_shift && instr_r.dest |=> file_wr_en && file_wr_data == {1'b0, $past(mem_rd_data[7:1])};
   endproperty
   a_shift_file: assert property (p_shift_file) else $error("shift result to file wrong");

   property p_shift_work;
      is_shift && !instr_r.dest |=> !file_wr_en && work_reg == {1'b0, $past(mem_rd_data[7:1])};
   endproperty
   a_shift_work: assert property (p_shift_work) else $error("shift result to working wrong");

   property p_move_zero;
      is_move |=> zero_flag == ($past(mem_rd_data) == `SMI_DATA_ZERO)
                  && (file_wr_en == $past(instr_r.dest));
   endproperty
   a_move_zero: assert property (p_move_zero) else $error("move zero or destination wrong");

   property p_pre_addr;
      take && instr.op == smi_pkg::op_iload && !instr.relative && !instr.pointer_update_mode[1]
      |=> mem_rd_addr == ptr_r[$past(instr.ptr_sel)] && mem_rd_indirect;
   endproperty
   a_pre_addr: assert property (p_pre_addr) else $error("pre-mode address wrong");

   property p_rel_addr;
      take && instr.op == smi_pkg::op_iload && instr.relative && !reg_wr
      |=> mem_rd_addr == 16'($past(sel_ptr) + {{10{$past(instr.offset[5])}}, $past(instr.offset)})
          && ptr_r[$past(instr.ptr_sel)] == $past(sel_ptr);
   endproperty
   a_rel_addr: assert property (p_rel_addr) else $error("relative address wrong");

   property p_post_step;
      is_iload && !instr_r.relative && instr_r.pointer_update_mode == smi_pkg::mode_post_dec
      |=> ptr_r[$past(instr_r.ptr_sel)] == 16'($past(mem_rd_addr) - `SMI_PTR_STEP);
   endproperty
   a_post_step: assert property (p_post_step) else $error("post-decrement wrong");

   property p_iload_work;
      is_iload |=> work_reg == $past(mem_rd_data) && carry_flag == $past(carry_flag) && !file_wr_en;
   endproperty
   a_iload_work: assert property (p_iload_work) else $error("indirect load result wrong");

   property p_done_time;
      take |-> ##3 instr_done;
   endproperty
   a_done_time: assert property (p_done_time) else $error("instruction not done in time");

   c_shift_file: cover property (is_shift && instr_r.dest);
   c_iload_pre:  cover property (is_iload && instr_r.pointer_update_mode == smi_pkg::mode_pre_dec);
   c_iload_rel:  cover property (is_iload && instr_r.relative);
   c_move_test:  cover property (is_move && instr_r.dest);

endmodule // smi_core

// [verif/test_shift_move_indirect_exec.sv]
// Self-checking bench for the shift, move and indirect-load block.
// Assumes smi_pkg and smi_core are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
module test_shift_move_indirect_exec;
   logic                mclk, srst, instr_valid, instr_ready, instr_done;
   smi_pkg::smi_instr_s instr;
   logic                mem_rd_en, mem_rd_indirect, file_wr_en, reg_wr, reg_rd, carry_flag, zero_flag;
   logic [15:0]         mem_rd_addr;
   logic [6:0]          file_wr_addr;
   logic [7:0]          mem_rd_data, file_wr_data, reg_wdata, reg_rdata, work_reg, w, rv;
   logic [2:0]          reg_addr;
   logic [31:0]         rn;
   logic                c, z;
   logic [15:0]         ptr [2];
   int                  error_cnt, n_checks, j;

   smi_core dut (
      .mclk(mclk), .srst(srst), .instr(instr), .instr_valid(instr_valid), .instr_ready(instr_ready),
      .instr_done(instr_done), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
      .mem_rd_indirect(mem_rd_indirect), .mem_rd_data(mem_rd_data), .file_wr_en(file_wr_en),
      .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .work_reg(work_reg), .carry_flag(carry_flag), .zero_flag(zero_flag)
   );

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   function automatic logic [7:0] mem_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8];
   endfunction

   // Memory answers one cycle after the strobe, scrambles otherwise
   always @(posedge mclk) begin
      if (srst) begin
         mem_rd_data <= 8'h00;
      end else if (mem_rd_en === 1'b1) begin
         mem_rd_data <= mem_val(mem_rd_addr);
      end else begin
         mem_rd_data <= ~mem_rd_data;
      end
   end

   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic setp(input logic s, input logic [15:0] v);
      wr(s ? 3'h4 : 3'h2, v[7:0]);
      wr(s ? 3'h5 : 3'h3, v[15:8]);
      ptr[s] = v;
   endtask

   task automatic pchk(input logic s);
      logic [7:0] d;
      rd(s ? 3'h4 : 3'h2, d);
      chk(d, ptr[s][7:0], "pointer low");
      rd(s ? 3'h5 : 3'h3, d);
      chk(d, ptr[s][15:8], "pointer high");
   endtask

   function automatic smi_pkg::smi_instr_s mk(input logic [1:0] op, input logic [6:0] fa, input logic d,
                                              input logic s, input logic r, input logic [1:0] m,
                                              input logic [5:0] o);
      return smi_pkg::smi_instr_s'({op, fa, d, s, r, m, o});
   endfunction

   task automatic exec(input smi_pkg::smi_instr_s i);
      logic [15:0] ea, np;
      logic [7:0]  opd, res;
      logic        ld, wf;
      int          k;
      for (k = 0; k < 8 && instr_ready !== 1'b1; k++) @(posedge mclk);
      if (instr_ready !== 1'b1) begin
         chk(0, 1, "ready timeout");
         final_report;
      end
      ld = (i.op == smi_pkg::op_iload);
      wf = !ld && i.dest;
      np = ptr[i.ptr_sel];
      ea = {9'h000, i.faddr};
      if (ld && i.relative) begin
         ea = np + {{10{i.offset[5]}}, i.offset};
      end else if (ld) begin
         case (i.pointer_update_mode)
            smi_pkg::mode_pre_inc: begin np = np + 16'h0001; ea = np; end
            smi_pkg::mode_pre_dec: begin np = np - 16'h0001; ea = np; end
            smi_pkg::mode_post_inc: begin ea = np; np = np + 16'h0001; end
            default: begin ea = np; np = np - 16'h0001; end
         endcase
      end
      opd = mem_val(ea);
      res = (i.op == smi_pkg::op_shift_right) ? {1'b0, opd[7:1]} : opd;
      @(posedge mclk);
      instr <= i;
      instr_valid <= 1'b1;
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
      chk(mem_rd_en, 1, "read strobe");
      chk(instr_ready, 0, "busy");
      chk(mem_rd_addr, ea, "address");
      chk(mem_rd_indirect, ld, "indirect");
      @(posedge mclk);
      @(posedge mclk);
      #1;
      if (i.op == smi_pkg::op_shift_right) c = opd[0];
      z = (res == 8'h00);
      if (!wf) w = res;
      ptr[i.ptr_sel] = np;
      chk(instr_done, 1, "done");
      chk(work_reg, w, "working");
      chk(carry_flag, c, "carry");
      chk(zero_flag, z, "zero");
      chk(file_wr_en, wf, "file write");
      if (wf) begin
         chk(file_wr_addr, i.faddr, "file addr");
         chk(file_wr_data, res, "file data");
      end
   endtask

   initial begin
      error_cnt = 0;
      n_checks = 0;
      srst = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      w = 8'h00;
      c = 1'b0;
      z = 1'b0;
      ptr[0] = 16'h0000;
      ptr[1] = 16'h0000;
      rv = $urandom(32'h7563E9F0);
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      #1;
      chk(instr_ready, 1, "ready after reset");
      rd(3'h1, rv);
      chk(rv, 8'h00, "status reset");
      @(posedge mclk);
      #1;
      chk(reg_rdata, 8'h00, "read data one cycle");
      rd(3'h6, rv);
      chk(rv, 8'h00, "unmapped read");
      wr(3'h7, 8'hFF);
      rd(3'h0, rv);
      chk(rv, w, "unmapped write");
      pchk(1'b0);
      // Pointer wrap at both ends
      setp(1'b0, 16'hFFFF);
      exec(mk(2'h2, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00));
      pchk(1'b0);
      setp(1'b1, 16'h0000);
      exec(mk(2'h2, 7'h00, 1'b1, 1'b1, 1'b0, 2'h1, 6'h00));
      pchk(1'b1);
      // Every mode and both offset limits
      for (j = 0; j < 4; j++) begin
         exec(mk(2'h2, 7'h00, 1'b0, 1'b1, 1'b0, j[1:0], 6'h00));
         pchk(1'b1);
      end
      exec(mk(2'h2, 7'h00, 1'b0, 1'b0, 1'b1, 2'h0, 6'h20));
      exec(mk(2'h2, 7'h00, 1'b0, 1'b0, 1'b1, 2'h3, 6'h1F));
      pchk(1'b0);
      // Shift to zero with carry out, shift of the top file, move of top and bottom files
      exec(mk(2'h0, 7'h01, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00));
      exec(mk(2'h0, 7'h7F, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00));
      exec(mk(2'h1, 7'h00, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00));
      exec(mk(2'h1, 7'h7F, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00));
      for (j = 0; j < 150; j++) begin
         rn = $urandom;
         exec(mk(rn[1:0], rn[8:2], rn[9], rn[10], rn[11], rn[13:12], rn[19:14]));
         if (rn[1:0] == 2'h2) pchk(rn[10]);
      end
      // Working and status written over the register port, carry kept by loads
      rn = $urandom;
      wr(3'h0, rn[7:0]);
      wr(3'h1, 8'hFE);
      w = rn[7:0];
      c = 1'b0;
      z = 1'b1;
      rd(3'h0, rv);
      chk(rv, w, "working write");
      rd(3'h1, rv);
      chk(rv, 8'h02, "status write zero");
      wr(3'h1, 8'h01);
      c = 1'b1;
      z = 1'b0;
      rd(3'h1, rv);
      chk(rv, 8'h01, "status write carry");
      exec(mk(2'h2, 7'h00, 1'b0, 1'b0, 1'b1, 2'h0, 6'h05));
      exec(mk(2'h2, 7'h00, 1'b0, 1'b1, 1'b0, 2'h2, 6'h00));
      pchk(1'b1);
      // Reset in mid-run clears pointers, working and flags
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      w = 8'h00;
      c = 1'b0;
      z = 1'b0;
      ptr[0] = 16'h0000;
      ptr[1] = 16'h0000;
      #1;
      chk(instr_ready, 1, "ready after second reset");
      chk(work_reg, w, "working after reset");
      chk({carry_flag, zero_flag}, 2'b00, "flags after reset");
      pchk(1'b0);
      pchk(1'b1);
      exec(mk(2'h2, 7'h00, 1'b0, 1'b0, 1'b0, 2'h1, 6'h00));
      pchk(1'b0);
      final_report;
   end
endmodule // test_shift_move_indirect_exec
